//--- pkg/rss_defines.svh
// Purpose: register offsets, field positions and reset values of the selector
// Assumes: included by bare name, definitions only
// Notes: byte addresses on a 32-bit AXI4-Lite slave
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSS_AW 8
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_RANGE_LO 8'h04
`define RSS_OFF_RANGE_HI 8'h08
`define RSS_OFF_STALE 8'h0C
`define RSS_OFF_STATUS 8'h10
`define RSS_OFF_NOTIFY 8'h14
`define RSS_OFF_VALUE 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSS_CTRL_NIN_LSB 0
`define RSS_CTRL_NIN_MSB 2
`define RSS_CTRL_SEL_BIT 4
`define RSS_CTRL_RUN_BIT 8
`define RSS_ST_GOOD_LSB 0
`define RSS_ST_MANUAL_BIT 8
`define RSS_ST_ALERT_BIT 9
`define RSS_ST_METH_LSB 12
`define RSS_ST_NIN_LSB 16

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define RSS_CTRL_RST 32'h0000_0104
`define RSS_RANGE_LO_RST 32'h0000_0000
`define RSS_RANGE_HI_RST 32'hFFFF_FFFF
`define RSS_STALE_RST 32'h0000_03E8
`define RSS_NIN_MIN 3'h2
`define RSS_NIN_MAX 3'h4
`define RSS_RESP_OKAY 2'h0
`define RSS_RESP_SLVERR 2'h2

`endif

//--- pkg/rss_pkg.sv
// Purpose: shared types of the redundant signal selector
// Assumes: constants live in rss_defines.svh
// Notes: method codes are visible in the status register
package rss_pkg;

  // how the control value is formed this cycle
  typedef enum logic [2:0] {
    RSS_M_MANUAL = 3'h0,
    RSS_M_SINGLE = 3'h1,
    RSS_M_MEAN2 = 3'h2,
    RSS_M_MED3 = 3'h3,
    RSS_M_MED4 = 3'h4,
    RSS_M_OPSEL = 3'h5
  } rss_method_t;

endpackage : rss_pkg

//--- rtl/rss_cmpx.sv
// Purpose: one compare-exchange stage of the ranking network
// Assumes: keys compare as unsigned numbers
// Notes: purely combinational
`timescale 1ns/1ps
module rss_cmpx #(
  parameter int KW = 19
) (
  input wire logic [KW-1:0] key_a,
  input wire logic [KW-1:0] key_b,
  output logic [KW-1:0] key_lo,
  output logic [KW-1:0] key_hi
);

  // smaller key to the low side
  wire swap = key_b < key_a;
  assign key_lo = swap ? key_b : key_a;
  assign key_hi = swap ? key_a : key_b;

endmodule : rss_cmpx

//--- rtl/rss_chan_check.sv
// Purpose: hold one channel's latest sample and judge it good or bad
// Assumes: samples arrive synchronous to clk_sys with a valid strobe
// Notes: bad when unused, flagged bad by link, bypassed, out of range or stale
`timescale 1ns/1ps
module rss_chan_check #(
  parameter int DW = 16,
  parameter int TW = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic used,
  input wire logic smp_valid,
  input wire logic [DW-1:0] smp_data,
  input wire logic smp_ok,
  input wire logic bypass,
  input wire logic [DW-1:0] range_lo,
  input wire logic [DW-1:0] range_hi,
  input wire logic [TW-1:0] stale_limit,
  output logic good,
  output logic [DW-1:0] value
);

  logic [DW-1:0] val_reg;
  logic ok_reg;
  logic seen_reg;
  logic [TW-1:0] age_reg;

  // latch sample, age it while no new one comes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      val_reg <= '0;
      ok_reg <= 1'b0;
      seen_reg <= 1'b0;
      age_reg <= '0;
    end else if (ce) begin
      if (smp_valid) begin
        val_reg <= smp_data;
        ok_reg <= smp_ok;
        seen_reg <= 1'b1;
        age_reg <= '0;
      end else if (age_reg != {TW{1'b1}}) begin
        age_reg <= age_reg + 1'b1;
      end
    end
  end

  // quality and validation checks
  wire in_range = (val_reg >= range_lo) && (val_reg <= range_hi);
  wire fresh = age_reg <= stale_limit;
  assign good = used && seen_reg && ok_reg && !bypass && in_range && fresh;
  assign value = val_reg;

endmodule : rss_chan_check

//--- rtl/rss_selector.sv
// Purpose: redundant-channel selector forming one control value
// Assumes: up to four redundant protection_system channels on one-way links
// Notes: registers over AXI4-Lite; clock enable ce freezes everything
//
// Functional notes
// [R1] every input is judged good or bad before selection
// [R2] four good inputs give the median of four
// [R3] an input turning bad raises an operator notification
// [R4] two-input mode, both good: operator-chosen input is passed
// [R5] two-input mode, one good: that input is passed
// [R6] two-input mode, none good: loop goes to manual control
// [R7] three good inputs: middle of lowest, middle, highest is passed
// [R8] three-input mode, one bad: mean of the two good inputs
// [R9] three-input mode, two bad: the single good input
// [R10] three-input mode, all bad: manual control and operator alert
// [R11] four-input mode, one bad: handled by the three-input method
// [R12] four-input mode, two bad: mean of two remaining good inputs
// [R13] four-input mode, one good: that input is passed
// [R14] four-input mode, all bad: manual control and operator alert
// [R15] far side sends data over isolated one-way links only
// [R16] far side trips on two of four channels
// [R17] median of four is mean of middle two, ties by channel index
`timescale 1ns/1ps
`include "rss_defines.svh"
module rss_selector #(
  parameter int DW = 16,
  parameter int TW = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] pv_valid,
  input wire logic [4*DW-1:0] pv_data,
  input wire logic [3:0] pv_ok,
  input wire logic [3:0] pv_bypass,
  output logic [DW-1:0] ctrl_value,
  output logic ctrl_valid,
  output logic ctrl_manual,
  output logic op_alert,
  output logic op_notify,
  input wire logic [`RSS_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RSS_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int KW = DW + 3;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] lo_reg;
  logic [31:0] hi_reg;
  logic [31:0] stale_reg;
  logic [3:0] notify_reg;
  logic [3:0] notify_next;
  logic [3:0] good_prev_reg;
  logic aw_held_reg;
  logic [`RSS_AW-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [DW-1:0] value_reg;
  logic valid_reg;
  logic manual_reg;
  logic alert_reg;
  logic notify_pulse_reg;
  rss_pkg::rss_method_t method_reg;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire [2:0] nin_raw = ctrl_reg[`RSS_CTRL_NIN_MSB:`RSS_CTRL_NIN_LSB];
  wire [2:0] nin = (nin_raw < `RSS_NIN_MIN) ? `RSS_NIN_MIN :
                   (nin_raw > `RSS_NIN_MAX) ? `RSS_NIN_MAX : nin_raw;
  wire op_sel = ctrl_reg[`RSS_CTRL_SEL_BIT];
  wire run = ctrl_reg[`RSS_CTRL_RUN_BIT];
  wire [3:0] used = {nin > 3'h3, nin > 3'h2, 1'b1, 1'b1};

  // ----------------------------------------------------------------
  // channel checks
  // ----------------------------------------------------------------
  logic [3:0] good;
  logic [DW-1:0] ch_val [4];

  // one checker per channel, good/bad before any selection
  for (genvar i = 0; i < 4; i++) begin : g_chan
    rss_chan_check #(
      .DW(DW),
      .TW(TW)
    ) u_check (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ce(ce),
      .used(used[i]),
      .smp_valid(pv_valid[i]),
      .smp_data(pv_data[i*DW +: DW]),
      .smp_ok(pv_ok[i]),
      .bypass(pv_bypass[i]),
      .range_lo(lo_reg[DW-1:0]),
      .range_hi(hi_reg[DW-1:0]),
      .stale_limit(stale_reg[TW-1:0]),
      .good(good[i]),
      .value(ch_val[i])
    ); // [R1]
  end

  // ----------------------------------------------------------------
  // ranking network
  // ----------------------------------------------------------------
  // key: bad flag on top pushes bad inputs last; index breaks ties
  wire [KW-1:0] k0 = {~good[0], ch_val[0], 2'h0}; // [R17]
  wire [KW-1:0] k1 = {~good[1], ch_val[1], 2'h1};
  wire [KW-1:0] k2 = {~good[2], ch_val[2], 2'h2};
  wire [KW-1:0] k3 = {~good[3], ch_val[3], 2'h3};
  logic [KW-1:0] a0, a1, a2, a3, b0, b1, b2, b3, s1, s2;

  // five compare-exchange stages sort four keys ascending
  rss_cmpx #(.KW(KW)) u_c0 (.key_a(k0), .key_b(k1), .key_lo(a0), .key_hi(a1));
  rss_cmpx #(.KW(KW)) u_c1 (.key_a(k2), .key_b(k3), .key_lo(a2), .key_hi(a3));
  rss_cmpx #(.KW(KW)) u_c2 (.key_a(a0), .key_b(a2), .key_lo(b0), .key_hi(b2));
  rss_cmpx #(.KW(KW)) u_c3 (.key_a(a1), .key_b(a3), .key_lo(b1), .key_hi(b3));
  rss_cmpx #(.KW(KW)) u_c4 (.key_a(b1), .key_b(b2), .key_lo(s1), .key_hi(s2));

  wire [DW-1:0] low_v = b0[KW-2:2];
  wire [DW-1:0] mid1_v = s1[KW-2:2];
  wire [DW-1:0] mid2_v = s2[KW-2:2];

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  wire [2:0] n_good = {2'h0, good[0]} + {2'h0, good[1]} + {2'h0, good[2]} +
                      {2'h0, good[3]};
  wire [DW:0] sum_low = {1'b0, low_v} + {1'b0, mid1_v};
  wire [DW:0] sum_mid = {1'b0, mid1_v} + {1'b0, mid2_v};
  wire [DW-1:0] mean_low = sum_low[DW:1];
  wire [DW-1:0] mean_mid = sum_mid[DW:1];
  wire [DW-1:0] op_val = ch_val[op_sel];
  wire two_mode = nin == `RSS_NIN_MIN;

  rss_pkg::rss_method_t meth;
  logic [DW-1:0] sel_val;

  // pick the method from the count of good inputs
  always_comb begin
    meth = rss_pkg::RSS_M_MANUAL;
    sel_val = value_reg;
    case (n_good)
      3'h4: begin
        meth = rss_pkg::RSS_M_MED4;
        sel_val = mean_mid; // [R2] [R17]
      end
      3'h3: begin
        meth = rss_pkg::RSS_M_MED3;
        sel_val = mid1_v; // [R7] [R11]
      end
      3'h2: begin
        if (two_mode) begin
          meth = rss_pkg::RSS_M_OPSEL;
          sel_val = op_val; // [R4]
        end else begin
          meth = rss_pkg::RSS_M_MEAN2;
          sel_val = mean_low; // [R8] [R12]
        end
      end
      3'h1: begin
        meth = rss_pkg::RSS_M_SINGLE;
        sel_val = low_v; // [R5] [R9] [R13]
      end
      default: begin
        meth = rss_pkg::RSS_M_MANUAL;
        sel_val = value_reg; // [R6] [R10] [R14]
      end
    endcase
  end

  wire no_good = n_good == 3'h0;
  wire go_manual = no_good || !run;

  // control value; last value is held while manual
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      value_reg <= '0;
      valid_reg <= 1'b0;
      manual_reg <= 1'b1;
      alert_reg <= 1'b0;
      method_reg <= rss_pkg::RSS_M_MANUAL;
    end else if (ce) begin
      value_reg <= go_manual ? value_reg : sel_val;
      valid_reg <= !go_manual;
      manual_reg <= go_manual; // [R6] [R10] [R14]
      alert_reg <= run && no_good; // [R10] [R14]
      method_reg <= go_manual ? rss_pkg::RSS_M_MANUAL : meth;
    end
  end

  // ----------------------------------------------------------------
  // bad-input notification
  // ----------------------------------------------------------------
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [3:0] bad_evt = good_prev_reg & ~good & used;
  wire notify_hit = wr_go && (aw_addr_reg == `RSS_OFF_NOTIFY) && w_strb_reg[0];
  wire [3:0] notify_clr = notify_hit ? w_data_reg[3:0] : 4'h0;
  assign notify_next = (notify_reg & ~notify_clr) | bad_evt;

  // sticky per-channel flags, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      good_prev_reg <= 4'h0;
      notify_reg <= 4'h0;
      notify_pulse_reg <= 1'b0;
    end else if (ce) begin
      good_prev_reg <= good;
      notify_reg <= notify_next; // [R3]
      notify_pulse_reg <= |bad_evt; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ce && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = ce && !w_held_reg && !bvalid_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wa_ctrl = aw_addr_reg == `RSS_OFF_CTRL;
  wire wa_lo = aw_addr_reg == `RSS_OFF_RANGE_LO;
  wire wa_hi = aw_addr_reg == `RSS_OFF_RANGE_HI;
  wire wa_stale = aw_addr_reg == `RSS_OFF_STALE;
  wire wa_ro = (aw_addr_reg == `RSS_OFF_STATUS) ||
               (aw_addr_reg == `RSS_OFF_NOTIFY) ||
               (aw_addr_reg == `RSS_OFF_VALUE);
  wire wa_hit = wa_ctrl || wa_lo || wa_hi || wa_stale || wa_ro;

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // address and data taken in either order, response after both
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RSS_RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wa_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // software-writable configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= `RSS_CTRL_RST;
      lo_reg <= `RSS_RANGE_LO_RST;
      hi_reg <= `RSS_RANGE_HI_RST;
      stale_reg <= `RSS_STALE_RST;
    end else if (ce && wr_go) begin
      if (wa_ctrl) ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
      if (wa_lo) lo_reg <= merge(lo_reg, w_data_reg, w_strb_reg);
      if (wa_hi) hi_reg <= merge(hi_reg, w_data_reg, w_strb_reg);
      if (wa_stale) stale_reg <= merge(stale_reg, w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ce && !rvalid_reg;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  wire [31:0] status_word = ({28'h0, good} << `RSS_ST_GOOD_LSB) |
                            ({31'h0, manual_reg} << `RSS_ST_MANUAL_BIT) |
                            ({31'h0, alert_reg} << `RSS_ST_ALERT_BIT) |
                            ({29'h0, method_reg} << `RSS_ST_METH_LSB) |
                            ({29'h0, nin} << `RSS_ST_NIN_LSB);
  wire ra_ctrl = s_axi_araddr == `RSS_OFF_CTRL;
  wire ra_lo = s_axi_araddr == `RSS_OFF_RANGE_LO;
  wire ra_hi = s_axi_araddr == `RSS_OFF_RANGE_HI;
  wire ra_stale = s_axi_araddr == `RSS_OFF_STALE;
  wire ra_status = s_axi_araddr == `RSS_OFF_STATUS;
  wire ra_notify = s_axi_araddr == `RSS_OFF_NOTIFY;
  wire ra_value = s_axi_araddr == `RSS_OFF_VALUE;
  wire ra_hit = ra_ctrl || ra_lo || ra_hi || ra_stale || ra_status ||
                ra_notify || ra_value;
  wire [31:0] rd_mux = ra_ctrl ? ctrl_reg :
                       ra_lo ? lo_reg :
                       ra_hi ? hi_reg :
                       ra_stale ? stale_reg :
                       ra_status ? status_word :
                       ra_notify ? {28'h0, notify_reg} :
                       ra_value ? {{(32-DW){1'b0}}, value_reg} : 32'h0000_0000;

  // read data latched at address acceptance
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RSS_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= ra_hit ? `RSS_RESP_OKAY : `RSS_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ctrl_value = value_reg;
  assign ctrl_valid = valid_reg;
  assign ctrl_manual = manual_reg;
  assign op_alert = alert_reg;
  assign op_notify = notify_pulse_reg;

endmodule : rss_selector

//--- tb/rss_selector_asserts.sv
// Purpose: port-level checks of the redundant signal selector
// Assumes: bound to every rss_selector instance
// Notes: one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module rss_selector_chk #(
  parameter int DW = 16,
  parameter int TW = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] pv_bypass,
  input wire logic [DW-1:0] ctrl_value,
  input wire logic ctrl_valid,
  input wire logic ctrl_manual,
  input wire logic op_alert,
  input wire logic op_notify,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ----
  // control value and mode
  // ----
  a_alert_manual: assert property (
    op_alert |-> ctrl_manual && !ctrl_valid)
    else $error("alert without manual control");
  a_auto_excl: assert property (
    ctrl_valid != ctrl_manual)
    else $error("automatic and manual disagree");
  a_manual_hold: assert property (
    ctrl_manual ##1 ctrl_manual |-> $stable(ctrl_value))
    else $error("value moved in manual");
  a_bypass_manual: assert property (
    pv_bypass == 4'hF ##1 pv_bypass == 4'hF |=> ctrl_manual)
    else $error("all bypassed but not manual");

  // ----
  // register bus
  // ----
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no write response");
  a_bresp_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");

  // main scenarios
  c_notify: cover property (op_notify);
  c_alert: cover property (op_alert);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : rss_selector_chk

bind rss_selector rss_selector_chk #(.DW(DW), .TW(TW)) u_rss_selector_chk (
  .clk_sys, .sys_rst, .pv_bypass, .ctrl_value, .ctrl_valid, .ctrl_manual, .op_alert,
  .op_notify, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

//--- tb/rss_chan_model.sv
// Purpose: far-side model of four redundant protection channels
// Assumes: bench sets val, ok and en by non-blocking assignment
// Notes: outputs only, nothing flows back from the selector
`timescale 1ns/1ps
module rss_chan_model (
  input wire logic clk_sys,
  output logic [3:0] pv_valid,
  output logic [63:0] pv_data,
  output logic [3:0] pv_ok,
  output logic trip
);
  logic [15:0] val [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] trip_lvl = 16'h03E8;
  logic [3:0] en = 4'hF;
  logic [3:0] ok = 4'hF;
  logic [2:0] n_trip;

  // ----
  // one-way sample lanes
  // ----
  assign pv_valid = en;
  assign pv_ok = ok;
  // a stopped lane shows the inverted last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pv_data[i*16 +: 16] = en[i] ? val[i] : ~val[i];
    end
  end

  // ----
  // two-of-four trip coincidence
  // ----
  always_comb begin
    n_trip = 3'h0;
    for (int i = 0; i < 4; i++) begin
      n_trip = n_trip + {2'h0, en[i] && val[i] > trip_lvl};
    end
  end
  // trip on two channels or more
  always_ff @(posedge clk_sys) begin
    trip <= n_trip >= 3'h2;
  end
endmodule : rss_chan_model

//--- tb/test_rss_selector.sv
// Purpose: self-checking bench of the redundant signal selector
// Assumes: rss_chan_model feeds the four channels
// Notes: registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`include "rss_defines.svh"
module test_rss_selector;
  // ----
  // signals
  // ----
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] pv_bypass = 4'h0;
  logic [3:0] pv_valid, pv_ok;
  logic [63:0] pv_data;
  logic [15:0] ctrl_value;
  logic ctrl_valid, ctrl_manual, op_alert, op_notify;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_fail = 0;
  int checks = 0;
  int n_note = 0;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  // count notification pulses toward the operator
  always @(posedge clk_sys) begin
    if (op_notify === 1'b1) n_note <= n_note + 1;
  end

  // far-side channels and the block
  rss_chan_model u_rss_chan_model (.clk_sys, .pv_valid, .pv_data, .pv_ok, .trip());
  rss_selector #(.DW(16), .TW(16)) u_rss_selector (
    .clk_sys, .sys_rst, .ce, .pv_valid, .pv_data, .pv_ok, .pv_bypass, .ctrl_value,
    .ctrl_valid, .ctrl_manual, .op_alert, .op_notify, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ----
  // checking and closing
  // ----
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task hang(input string nm);
    n_fail++;
    $display("Error %s expected answer seen none", nm);
    results();
  endtask : hang

  // ----
  // register bus
  // ----
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
        done = 1'b1;
      end
    end
    if (!done) hang("bvalid");
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        done = 1'b1;
      end
    end
    if (!done) hang("rvalid");
  endtask : rd

  // ----
  // channel stimulus
  // ----
  task vals(input logic [15:0] a, b, c, d);
    @(posedge clk_sys);
    u_rss_chan_model.val[0] <= a;
    u_rss_chan_model.val[1] <= b;
    u_rss_chan_model.val[2] <= c;
    u_rss_chan_model.val[3] <= d;
  endtask : vals

  // set link status and bypass, let four edges pass, compare outputs
  task scen(input logic [3:0] okm, byp, input logic [15:0] exp, input logic man);
    @(posedge clk_sys);
    u_rss_chan_model.ok <= okm;
    pv_bypass <= byp;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("ctrl_manual", man, ctrl_manual);
    chk("op_alert", man, op_alert);
    chk("ctrl_valid", !man, ctrl_valid);
    chk("ctrl_value", exp, ctrl_value);
  endtask : scen

  // ----
  // main sequence
  // ----
  initial begin
    repeat (5) @(posedge clk_sys);
    chk("ctrl_manual", 32'h1, ctrl_manual);
    sys_rst <= 1'b0;
    rd(`RSS_OFF_CTRL, `RSS_CTRL_RST, `RSS_RESP_OKAY);
    rd(`RSS_OFF_RANGE_LO, `RSS_RANGE_LO_RST, `RSS_RESP_OKAY);
    rd(`RSS_OFF_RANGE_HI, `RSS_RANGE_HI_RST, `RSS_RESP_OKAY);
    rd(`RSS_OFF_STALE, `RSS_STALE_RST, `RSS_RESP_OKAY);
    rd(`RSS_OFF_NOTIFY, 32'h0, `RSS_RESP_OKAY);
    rd(8'h1C, 32'h0, `RSS_RESP_SLVERR);
    wr(8'h1C, 32'hFFFF_FFFF, `RSS_RESP_SLVERR);
    wr(`RSS_OFF_STATUS, 32'h0, `RSS_RESP_OKAY);
    rd(`RSS_OFF_CTRL, `RSS_CTRL_RST, `RSS_RESP_OKAY);
    $display("test registers done");
    vals(16'h0064, 16'h0193, 16'h00C8, 16'h0136);
    scen(4'hF, 4'h0, 16'h00FF, 1'b0);
    rd(`RSS_OFF_STATUS, 32'h0004_400F, `RSS_RESP_OKAY);
    rd(`RSS_OFF_VALUE, 32'h0000_00FF, `RSS_RESP_OKAY);
    wr(`RSS_OFF_NOTIFY, 32'h0000_000F, `RSS_RESP_OKAY);
    scen(4'hD, 4'h0, 16'h00C8, 1'b0);
    rd(`RSS_OFF_NOTIFY, 32'h0000_0002, `RSS_RESP_OKAY);
    chk("op_notify", 32'h1, n_note);
    scen(4'hF, 4'hC, 16'h00FB, 1'b0);
    scen(4'h2, 4'h0, 16'h0193, 1'b0);
    scen(4'hF, 4'hF, 16'h0193, 1'b1);
    $display("test four inputs done");
    wr(`RSS_OFF_CTRL, 32'h0000_0103, `RSS_RESP_OKAY);
    vals(16'h02BC, 16'h0064, 16'h0190, 16'h0009);
    scen(4'hF, 4'h0, 16'h0190, 1'b0);
    scen(4'hE, 4'h0, 16'h00FA, 1'b0);
    scen(4'hC, 4'h0, 16'h0190, 1'b0);
    scen(4'h8, 4'h0, 16'h0190, 1'b1);
    $display("test three inputs done");
    wr(`RSS_OFF_CTRL, 32'h0000_0102, `RSS_RESP_OKAY);
    scen(4'hF, 4'h0, 16'h02BC, 1'b0);
    wr(`RSS_OFF_CTRL, 32'h0000_0112, `RSS_RESP_OKAY);
    scen(4'hF, 4'h0, 16'h0064, 1'b0);
    scen(4'hF, 4'h2, 16'h02BC, 1'b0);
    scen(4'hF, 4'h3, 16'h02BC, 1'b1);
    $display("test two inputs done");
    wr(`RSS_OFF_CTRL, 32'h0000_0104, `RSS_RESP_OKAY);
    wr(`RSS_OFF_RANGE_HI, 32'h0000_01F4, `RSS_RESP_OKAY);
    vals(16'h0064, 16'h00C8, 16'h012C, 16'h0258);
    scen(4'hF, 4'h0, 16'h00C8, 1'b0);
    wr(`RSS_OFF_STALE, 32'h0000_0014, `RSS_RESP_OKAY);
    u_rss_chan_model.en <= 4'hE;
    repeat (30) @(posedge clk_sys);
    scen(4'hF, 4'h0, 16'h00FA, 1'b0);
    // clock enable low: links drop but outputs stay frozen
    ce <= 1'b0;
    scen(4'h0, 4'h0, 16'h00FA, 1'b0);
    ce <= 1'b1;
    $display("test validation done");
    results();
  end
endmodule : test_rss_selector
